// ---- tb_top.sv ----
// self-checking bench for the weld step timing and monitor block
`timescale 1ns/1ps
`include "wst_params.svh"
module tb_top;
   import wst_pkg::*;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wr_data_i = 32'h0;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic [31:0] rd_data_o;
   logic line_tick_i;
   wst_ka_t meas_current_i;
   wst_ka_t level = 14'h0;
   logic fire_o;
   wst_pct_t fire_width_o;
   logic electrode_close_o;
   wst_state_t step_o;
   logic irq_o;
   logic rd_pend = 1'b0;
   int error_cnt = 0;
   int comparisons = 0;
   int n;
   logic [31:0] rd_q[$];
   logic [6:0] fire_q[$];
   logic [6:0] h1;
   logic [6:0] h2;
   initial begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   wst_top dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
      .line_tick_i(line_tick_i), .meas_current_i(meas_current_i), .fire_o(fire_o),
      .fire_width_o(fire_width_o), .electrode_close_o(electrode_close_o), .step_o(step_o),
      .irq_o(irq_o));
   wst_contactor line_u (.clk_i(sys_clk_i), .level_i(level), .tick_o(line_tick_i),
      .meas_o(meas_current_i));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_en_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_en_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_en_i <= 1'b0;
   endtask : rd
   // results are compared against the oldest note as they appear
   always @(posedge sys_clk_i) begin
      if (rd_pend) chk(rd_data_o, rd_q.pop_front());
      if (fire_o === 1'b1) chk({25'h0, fire_width_o}, {25'h0, fire_q.pop_front()});
      rd_pend <= rd_en_i;
   end
   task automatic results;
      $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   // a missing done interrupt shows up as a failed level check here
   task automatic wait_irq;
      n = 0;
      while (irq_o !== 1'b1 && n < 4000) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk({31'h0, irq_o}, 32'h1);
      chk({28'h0, electrode_close_o, step_o}, {28'h0, 1'b0, WST_IDLE});
   endtask : wait_irq
   initial begin
      #200000;
      error_cnt++;
      results();
   end
   initial begin
      void'($urandom(32'hEF1C4834));
      h1 = 7'(10 + $urandom_range(79));
      h2 = 7'(10 + $urandom_range(79));
      level = 14'(100 + $urandom_range(8800));
      repeat (12) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      rd(`WST_ADDR_TIME1, 32'h01000000);
      rd(8'h30, 32'h0);
      wr(`WST_ADDR_HEAT, 32'h0000FFFF);
      rd(`WST_ADDR_HEAT, 32'h00006363);
      wr(`WST_ADDR_TIME1, 32'h0);
      rd(`WST_ADDR_TIME1, 32'h01000000);
      wr(`WST_ADDR_TIME1, 32'h01000001);
      wr(`WST_ADDR_TIME2, 32'h00000002);
      wr(`WST_ADDR_HEAT, {16'h0, 1'b0, h2, 1'b0, h1});
      wr(`WST_ADDR_ILIM1, {2'b0, level, 16'h270F});
      wr(`WST_ADDR_ILIM2, {18'h0, level});
      wr(`WST_ADDR_PWLIM, {8'h00, 1'b0, h2, 1'b0, h1, 8'h63});
      wr(`WST_ADDR_PREOFF, 32'h00000A00);
      wr(`WST_ADDR_MASK, 32'h00001000);
      fire_q = '{h1, h2, h2};
      wr(`WST_ADDR_CTRL, 32'h000001E9);
      #1;
      chk({28'h0, electrode_close_o, step_o}, {28'h0, 1'b1, WST_FIRST_WELD_STEP});
      wait_irq();
      rd(`WST_ADDR_STATUS, 32'h00001562);
      chk(32'(fire_q.size()), 32'h0);
      wr(`WST_ADDR_MASK, 32'h0);
      #1;
      chk({31'h0, irq_o}, 32'h0);
      wr(`WST_ADDR_STATUS, 32'h00001FFF);
      rd(`WST_ADDR_STATUS, 32'h0);
      // second schedule: two impulses with slope, regulated first step, repeat mode
      wr(`WST_ADDR_TIME1, 32'h02010101);
      wr(`WST_ADDR_TIME2, 32'h01010001);
      wr(`WST_ADDR_TARGET, {18'h0, level + 14'h1});
      wr(`WST_ADDR_PREOFF, 32'h0000000A);
      wr(`WST_ADDR_MASK, 32'h00001000);
      fire_q = '{h2 + 7'h1, h2, h2 + 7'h1, h2, h2, h2};
      wr(`WST_ADDR_CTRL, 32'h0000021B);
      wait_irq();
      rd(`WST_ADDR_STATUS, 32'h0000100A);
      rd(`WST_ADDR_STATE, {1'b0, h2, 24'h0});
      chk(32'(fire_q.size()), 32'h0);
      repeat (4) @(posedge sys_clk_i);
      results();
   end
endmodule : tb_top

// ---- wst_accum.sv ----
// per-step sums of measured current and fired pulse width
`timescale 1ns/1ps
module wst_accum #(
   parameter int CW = 14,
   parameter int PW = 7,
   parameter int NW = 15,
   parameter int SCW = 29,
   parameter int SPW = 22
) (
   input wire logic sys_clk_i, // system clock
   input wire logic nrst_i, // sync reset, active low
   input wire logic clr_i, // restart sums
   input wire logic add_i, // one conducting cycle
   input wire logic [CW-1:0] cur_i, // measured current
   input wire logic [PW-1:0] pw_i, // fired width
   output logic [SCW-1:0] sum_cur_o, // current sum
   output logic [SPW-1:0] sum_pw_o, // width sum
   output logic [NW-1:0] n_o // conducting cycles
);

   // clear has priority: a step boundary never carries a cycle over
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i || clr_i) begin
         sum_cur_o <= '0;
         sum_pw_o <= '0;
         n_o <= '0;
      end else if (add_i) begin
         sum_cur_o <= sum_cur_o + SCW'(cur_i);
         sum_pw_o <= sum_pw_o + SPW'(pw_i);
         n_o <= n_o + NW'(1);
      end
   end

endmodule : wst_accum

// ---- wst_contactor.sv ----
// line supply and contactor model: free-running line marker and sensed current
`timescale 1ns/1ps
module wst_contactor #(
   parameter int PERIOD = 40
) (
   input wire logic clk_i, // clock
   input wire wst_pkg::wst_ka_t level_i, // delivered current
   output logic tick_o, // line marker
   output wst_pkg::wst_ka_t meas_o // sensed current
);
   import wst_pkg::*;
   int cnt = 0;
   // mains runs free, so the marker never stops between welds
   initial tick_o = 1'b0;
   always @(posedge clk_i) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      tick_o <= (cnt < PERIOD / 2);
   end
   assign meas_o = level_i;
endmodule : wst_contactor

// ---- wst_limit.sv ----
// inclusive high, low and pre-limit checks of a step average
`timescale 1ns/1ps
`include "wst_params.svh"
module wst_limit #(
   parameter int VW = 29,
   parameter int LW = 14,
   parameter int NW = 15
) (
   input wire logic [VW-1:0] sum_i, // sum over the step
   input wire logic [NW-1:0] n_i, // cycles in the sum
   input wire logic [LW-1:0] hi_i, // high limit
   input wire logic [LW-1:0] lo_i, // low limit
   input wire logic [6:0] off_i, // pre-limit offset percent
   input wire logic en_i, // limit check on
   input wire logic pre_en_i, // pre-limit check on
   output logic hi_o, // average at or above high
   output logic lo_o, // average at or below low
   output logic phi_o, // average at or above pre-high
   output logic plo_o // average at or below pre-low
);

   // average is never divided out: sum is compared with limit times n
   logic [47:0] s100;
   logic [47:0] hin;
   logic [47:0] lon;
   logic [47:0] phin;
   logic [47:0] plon;
   logic ok;

   always_comb begin
      s100 = 48'(sum_i) * `WST_PCT_FULL;
      hin = 48'(hi_i) * 48'(n_i) * `WST_PCT_FULL;
      lon = 48'(lo_i) * 48'(n_i) * `WST_PCT_FULL;
      phin = 48'(hi_i) * 48'(n_i) * (`WST_PCT_FULL - 48'(off_i));
      plon = 48'(lo_i) * 48'(n_i) * (`WST_PCT_FULL + 48'(off_i));
      ok = en_i && (n_i != '0);
      hi_o = ok && (s100 >= hin);
      lo_o = ok && (s100 <= lon);
      phi_o = ok && pre_en_i && (s100 >= phin);
      plo_o = ok && pre_en_i && (s100 <= plon);
   end

endmodule : wst_limit

// ---- wst_params.svh ----
// constants for the weld step timing and monitor block
`ifndef WST_PARAMS_SVH
`define WST_PARAMS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define WST_ADDR_CTRL 8'h00
`define WST_ADDR_TIME1 8'h04
`define WST_ADDR_TIME2 8'h08
`define WST_ADDR_HEAT 8'h0C
`define WST_ADDR_TARGET 8'h10
`define WST_ADDR_ILIM1 8'h14
`define WST_ADDR_ILIM2 8'h18
`define WST_ADDR_PWLIM 8'h1C
`define WST_ADDR_PREOFF 8'h20
`define WST_ADDR_STATUS 8'h24
`define WST_ADDR_MASK 8'h28
`define WST_ADDR_STATE 8'h2C

// ----------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------
`define WST_CTRL_START 0
`define WST_CTRL_CC1 1
`define WST_CTRL_CC2 2
`define WST_CTRL_I1EN 3
`define WST_CTRL_PRE1EN 4
`define WST_CTRL_PW1EN 5
`define WST_CTRL_I2EN 6
`define WST_CTRL_PRE2EN 7
`define WST_CTRL_PW2EN 8
`define WST_CTRL_REPEAT 9

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define WST_ST_I1HI 0
`define WST_ST_I1LO 1
`define WST_ST_PI1HI 2
`define WST_ST_PI1LO 3
`define WST_ST_PW1HI 4
`define WST_ST_PW1LO 5
`define WST_ST_I2HI 6
`define WST_ST_I2LO 7
`define WST_ST_PI2HI 8
`define WST_ST_PI2LO 9
`define WST_ST_PW2HI 10
`define WST_ST_PW2LO 11
`define WST_ST_DONE 12
`define WST_ST_W 13

// ----------------------------------------------------------------
// ranges and reset values
// ----------------------------------------------------------------
`define WST_PCT_MAX 7'd99
`define WST_CYC_MAX 7'd99
`define WST_KA_MAX 14'd9999
`define WST_PCT_FULL 48'd100
`define WST_RST_IMPULSES 7'h01
`define WST_RST_WORD 32'h00000000

`endif

// ---- wst_pkg.sv ----
// types shared by the weld step timing and monitor block
package wst_pkg;

   typedef enum logic [2:0] {
      WST_IDLE, WST_FIRST_WELD_STEP, WST_SLOPE, WST_FIRST_COOL_TIME,
      WST_SECOND_WELD_STEP, WST_SECOND_COOL_TIME, WST_HOLD, WST_OFF
   } wst_state_t;

   typedef logic [6:0] wst_pct_t;
   typedef logic [13:0] wst_ka_t;

endpackage : wst_pkg

// ---- wst_top.sv ----
// weld step sequencer, firing width control and end-of-step monitor
`timescale 1ns/1ps
`include "wst_params.svh"
module wst_top (
   input wire logic sys_clk_i, // 200 MHz system clock
   input wire logic nrst_i, // sync reset, active low
   input wire logic [7:0] addr_i, // register byte address
   input wire logic [31:0] wr_data_i, // register write data
   input wire logic wr_en_i, // write strobe
   input wire logic rd_en_i, // read strobe
   output logic [31:0] rd_data_o, // read data, cycle after strobe
   input wire logic line_tick_i, // line cycle marker pin
   input wire wst_pkg::wst_ka_t meas_current_i, // measured current
   output logic fire_o, // one-clock firing command
   output wst_pkg::wst_pct_t fire_width_o, // firing width percent
   output logic electrode_close_o, // electrodes held on part
   output wst_pkg::wst_state_t step_o, // current step
   output logic irq_o // level interrupt
);
   import wst_pkg::*;

   // ----------------------------------------------------------------
   // clamping of programmed values
   // ----------------------------------------------------------------
   function automatic wst_pct_t clamp_pct(input logic [7:0] v);
      clamp_pct = (v > 8'(`WST_PCT_MAX)) ? `WST_PCT_MAX : v[6:0];
   endfunction : clamp_pct

   function automatic wst_ka_t clamp_ka(input logic [15:0] v);
      clamp_ka = (v > 16'(`WST_KA_MAX)) ? `WST_KA_MAX : v[13:0];
   endfunction : clamp_ka

   // ----------------------------------------------------------------
   // schedule registers
   // ----------------------------------------------------------------
   logic [9:1] ctrl;
   wst_pct_t first_weld_step_time, first_cool_time, slope_time, impulses;
   wst_pct_t second_weld_step_time, second_cool_time, hold_time, off_time;
   wst_pct_t heat1, heat2, off1, off2;
   wst_pct_t pw1_hi, pw1_lo, pw2_hi, pw2_lo;
   wst_ka_t target1, target2, i1_hi, i1_lo, i2_hi, i2_lo;
   logic [`WST_ST_W-1:0] status, mask, set_vec;
   logic start_req;
   wst_pct_t imp_max;

   assign start_req = wr_en_i && (addr_i == `WST_ADDR_CTRL) && wr_data_i[`WST_CTRL_START];
   // an impulse count of zero is taken as one
   assign imp_max = clamp_pct(wr_data_i[31:24]);

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         ctrl <= '0;
         {first_weld_step_time, first_cool_time, slope_time} <= '0;
         impulses <= `WST_RST_IMPULSES;
         {second_weld_step_time, second_cool_time, hold_time, off_time} <= '0;
         {heat1, heat2, off1, off2} <= '0;
         {pw1_hi, pw1_lo, pw2_hi, pw2_lo} <= '0;
         {target1, target2, i1_hi, i1_lo, i2_hi, i2_lo} <= '0;
         mask <= '0;
      end else if (wr_en_i) begin
         unique case (addr_i)
            `WST_ADDR_CTRL: ctrl <= wr_data_i[9:1];
            `WST_ADDR_TIME1: begin
               first_weld_step_time <= clamp_pct(wr_data_i[7:0]);
               first_cool_time <= clamp_pct(wr_data_i[15:8]);
               slope_time <= clamp_pct(wr_data_i[23:16]);
               impulses <= (imp_max == '0) ? `WST_RST_IMPULSES : imp_max;
            end
            `WST_ADDR_TIME2: begin
               second_weld_step_time <= clamp_pct(wr_data_i[7:0]);
               second_cool_time <= clamp_pct(wr_data_i[15:8]);
               hold_time <= clamp_pct(wr_data_i[23:16]);
               off_time <= clamp_pct(wr_data_i[31:24]);
            end
            `WST_ADDR_HEAT: begin
               heat1 <= clamp_pct(wr_data_i[7:0]);
               heat2 <= clamp_pct(wr_data_i[15:8]);
            end
            `WST_ADDR_TARGET: begin
               target1 <= clamp_ka(wr_data_i[15:0]);
               target2 <= clamp_ka(wr_data_i[31:16]);
            end
            `WST_ADDR_ILIM1: begin
               i1_hi <= clamp_ka(wr_data_i[15:0]);
               i1_lo <= clamp_ka(wr_data_i[31:16]);
            end
            `WST_ADDR_ILIM2: begin
               i2_hi <= clamp_ka(wr_data_i[15:0]);
               i2_lo <= clamp_ka(wr_data_i[31:16]);
            end
            `WST_ADDR_PWLIM: begin
               pw1_hi <= clamp_pct(wr_data_i[7:0]);
               pw1_lo <= clamp_pct(wr_data_i[15:8]);
               pw2_hi <= clamp_pct(wr_data_i[23:16]);
               pw2_lo <= clamp_pct(wr_data_i[31:24]);
            end
            `WST_ADDR_PREOFF: begin
               off1 <= clamp_pct(wr_data_i[7:0]);
               off2 <= clamp_pct(wr_data_i[15:8]);
            end
            `WST_ADDR_MASK: mask <= wr_data_i[`WST_ST_W-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // line cycle tick from the pin
   // ----------------------------------------------------------------
   logic tick_s1, tick_s2, tick_s3, tick;

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         {tick_s1, tick_s2, tick_s3} <= '0;
      end else begin
         tick_s1 <= line_tick_i;
         tick_s2 <= tick_s1;
         tick_s3 <= tick_s2;
      end
   end

   assign tick = tick_s2 && !tick_s3;

   // ----------------------------------------------------------------
   // step sequencer
   // ----------------------------------------------------------------
   wst_state_t state;
   wst_pct_t cnt, imp, step_time;
   logic step_end, conduct, chk1, chk2, seq_done;

   always_comb begin
      unique case (state)
         WST_FIRST_WELD_STEP: step_time = first_weld_step_time;
         WST_SLOPE: step_time = slope_time;
         WST_FIRST_COOL_TIME: step_time = first_cool_time;
         WST_SECOND_WELD_STEP: step_time = second_weld_step_time;
         WST_SECOND_COOL_TIME: step_time = second_cool_time;
         WST_HOLD: step_time = hold_time;
         WST_OFF: step_time = off_time;
         WST_IDLE: step_time = '0;
      endcase
   end

   // a step of n cycles spends n ticks counting and one more to move on,
   // so a zero time, other than a skipped zero slope, still costs one line cycle but never conducts
   assign step_end = tick && (state != WST_IDLE) && (cnt >= step_time);
   assign conduct = tick && (cnt < step_time) &&
      (state == WST_FIRST_WELD_STEP || state == WST_SLOPE || state == WST_SECOND_WELD_STEP);
   assign chk1 = step_end && (state == WST_FIRST_COOL_TIME) && (imp + 7'd1 >= impulses);
   assign chk2 = step_end && (state == WST_SECOND_COOL_TIME) && (imp + 7'd1 >= impulses);
   assign seq_done = step_end && ((state == WST_OFF) ||
      (state == WST_HOLD && !ctrl[`WST_CTRL_REPEAT]));

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         state <= WST_IDLE;
         cnt <= '0;
         imp <= '0;
      end else if (state == WST_IDLE) begin
         cnt <= '0;
         imp <= '0;
         if (start_req) state <= WST_FIRST_WELD_STEP;
      end else if (step_end) begin
         cnt <= '0;
         unique case (state)
            WST_FIRST_WELD_STEP: state <= (slope_time != '0) ? WST_SLOPE : WST_FIRST_COOL_TIME;
            WST_SLOPE: state <= WST_FIRST_COOL_TIME;
            WST_FIRST_COOL_TIME: begin
               imp <= chk1 ? '0 : imp + 7'd1;
               state <= chk1 ? WST_SECOND_WELD_STEP : WST_FIRST_WELD_STEP;
            end
            WST_SECOND_WELD_STEP: state <= WST_SECOND_COOL_TIME;
            WST_SECOND_COOL_TIME: begin
               imp <= chk2 ? '0 : imp + 7'd1;
               state <= chk2 ? WST_HOLD : WST_SECOND_WELD_STEP;
            end
            WST_HOLD: state <= ctrl[`WST_CTRL_REPEAT] ? WST_OFF : WST_IDLE;
            WST_OFF: state <= WST_IDLE;
            WST_IDLE: state <= WST_IDLE;
         endcase
      end else if (tick) begin
         cnt <= cnt + 7'd1;
      end
   end

   // electrodes stay down through every step up to and including hold, and lift for off
   assign electrode_close_o = (state != WST_IDLE) && (state != WST_OFF);
   assign step_o = state;

   // ----------------------------------------------------------------
   // firing width regulation
   // ----------------------------------------------------------------
   wst_ka_t meas_q;

   function automatic wst_pct_t cc_step(input wst_pct_t w, input wst_ka_t tgt,
                                        input wst_ka_t meas);
      if (meas < tgt && w < `WST_PCT_MAX) cc_step = w + 7'd1;
      else if (meas > tgt && w != '0) cc_step = w - 7'd1;
      else cc_step = w;
   endfunction : cc_step

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         fire_o <= 1'b0;
         fire_width_o <= '0;
         meas_q <= '0;
      end else begin
         fire_o <= conduct;
         if (conduct) begin
            meas_q <= meas_current_i;
            unique case (state)
               WST_FIRST_WELD_STEP: fire_width_o <= ctrl[`WST_CTRL_CC1] ?
                  cc_step(fire_width_o, target1, meas_current_i) : heat1;
               // slope walks the width one percent a cycle toward the second heat
               WST_SLOPE: fire_width_o <= (fire_width_o < heat2) ? fire_width_o + 7'd1 :
                  (fire_width_o > heat2) ? fire_width_o - 7'd1 : fire_width_o;
               WST_SECOND_WELD_STEP: fire_width_o <= ctrl[`WST_CTRL_CC2] ?
                  cc_step(fire_width_o, target2, meas_current_i) : heat2;
               default: fire_width_o <= fire_width_o;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // step averages and limit checks
   // ----------------------------------------------------------------
   logic [28:0] sum_cur;
   logic [21:0] sum_pw;
   logic [14:0] n_cyc;
   logic [3:0] f_i1, f_i2, f_pw1, f_pw2;

   // sums restart at start and when the last first cool time ends; fire_o marks the cycle just fired
   wst_accum u_accum (
      .sys_clk_i (sys_clk_i),
      .nrst_i (nrst_i),
      .clr_i (start_req || chk1),
      .add_i (fire_o),
      .cur_i (meas_q),
      .pw_i (fire_width_o),
      .sum_cur_o (sum_cur),
      .sum_pw_o (sum_pw),
      .n_o (n_cyc)
   );

   wst_limit #(.VW(29), .LW(14)) u_lim_i1 (
      .sum_i (sum_cur), .n_i (n_cyc), .hi_i (i1_hi), .lo_i (i1_lo), .off_i (off1),
      .en_i (ctrl[`WST_CTRL_I1EN]), .pre_en_i (ctrl[`WST_CTRL_PRE1EN]),
      .hi_o (f_i1[0]), .lo_o (f_i1[1]), .phi_o (f_i1[2]), .plo_o (f_i1[3])
   );

   wst_limit #(.VW(29), .LW(14)) u_lim_i2 (
      .sum_i (sum_cur), .n_i (n_cyc), .hi_i (i2_hi), .lo_i (i2_lo), .off_i (off2),
      .en_i (ctrl[`WST_CTRL_I2EN]), .pre_en_i (ctrl[`WST_CTRL_PRE2EN]),
      .hi_o (f_i2[0]), .lo_o (f_i2[1]), .phi_o (f_i2[2]), .plo_o (f_i2[3])
   );

   wst_limit #(.VW(22), .LW(7)) u_lim_pw1 (
      .sum_i (sum_pw), .n_i (n_cyc), .hi_i (pw1_hi), .lo_i (pw1_lo), .off_i ('0),
      .en_i (ctrl[`WST_CTRL_PW1EN]), .pre_en_i (1'b0),
      .hi_o (f_pw1[0]), .lo_o (f_pw1[1]), .phi_o (f_pw1[2]), .plo_o (f_pw1[3])
   );

   wst_limit #(.VW(22), .LW(7)) u_lim_pw2 (
      .sum_i (sum_pw), .n_i (n_cyc), .hi_i (pw2_hi), .lo_i (pw2_lo), .off_i ('0),
      .en_i (ctrl[`WST_CTRL_PW2EN]), .pre_en_i (1'b0),
      .hi_o (f_pw2[0]), .lo_o (f_pw2[1]), .phi_o (f_pw2[2]), .plo_o (f_pw2[3])
   );

   // checks are sampled once, in the cycle that closes the last cool time of each impulse group
   always_comb begin
      set_vec = '0;
      set_vec[`WST_ST_I1HI] = chk1 && f_i1[0];
      set_vec[`WST_ST_I1LO] = chk1 && f_i1[1];
      set_vec[`WST_ST_PI1HI] = chk1 && f_i1[2];
      set_vec[`WST_ST_PI1LO] = chk1 && f_i1[3];
      set_vec[`WST_ST_PW1HI] = chk1 && f_pw1[0];
      set_vec[`WST_ST_PW1LO] = chk1 && f_pw1[1];
      set_vec[`WST_ST_I2HI] = chk2 && f_i2[0];
      set_vec[`WST_ST_I2LO] = chk2 && f_i2[1];
      set_vec[`WST_ST_PI2HI] = chk2 && f_i2[2];
      set_vec[`WST_ST_PI2LO] = chk2 && f_i2[3];
      set_vec[`WST_ST_PW2HI] = chk2 && f_pw2[0];
      set_vec[`WST_ST_PW2LO] = chk2 && f_pw2[1];
      set_vec[`WST_ST_DONE] = seq_done;
   end

   // ----------------------------------------------------------------
   // status, interrupt and read port
   // ----------------------------------------------------------------
   logic [`WST_ST_W-1:0] w1c;

   assign w1c = (wr_en_i && addr_i == `WST_ADDR_STATUS) ? wr_data_i[`WST_ST_W-1:0] : '0;

   // a new event outranks a clear written in the same cycle
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) status <= '0;
      else status <= (status & ~w1c) | set_vec;
   end

   assign irq_o = |(status & mask);

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         rd_data_o <= `WST_RST_WORD;
      end else if (rd_en_i) begin
         unique case (addr_i)
            `WST_ADDR_CTRL: rd_data_o <= {22'h0, ctrl, 1'b0};
            `WST_ADDR_TIME1: rd_data_o <= {1'b0, impulses, 1'b0, slope_time,
                                          1'b0, first_cool_time, 1'b0, first_weld_step_time};
            `WST_ADDR_TIME2: rd_data_o <= {1'b0, off_time, 1'b0, hold_time,
                                          1'b0, second_cool_time, 1'b0, second_weld_step_time};
            `WST_ADDR_HEAT: rd_data_o <= {17'h0, heat2, 1'b0, heat1};
            `WST_ADDR_TARGET: rd_data_o <= {2'h0, target2, 2'h0, target1};
            `WST_ADDR_ILIM1: rd_data_o <= {2'h0, i1_lo, 2'h0, i1_hi};
            `WST_ADDR_ILIM2: rd_data_o <= {2'h0, i2_lo, 2'h0, i2_hi};
            `WST_ADDR_PWLIM: rd_data_o <= {1'b0, pw2_lo, 1'b0, pw2_hi,
                                          1'b0, pw1_lo, 1'b0, pw1_hi};
            `WST_ADDR_PREOFF: rd_data_o <= {17'h0, off2, 1'b0, off1};
            `WST_ADDR_STATUS: rd_data_o <= {19'h0, status};
            `WST_ADDR_MASK: rd_data_o <= {19'h0, mask};
            `WST_ADDR_STATE: rd_data_o <= {1'b0, fire_width_o, 1'b0, imp,
                                          1'b0, cnt, 5'h0, state};
            default: rd_data_o <= `WST_RST_WORD;
         endcase
      end else begin
         rd_data_o <= `WST_RST_WORD;
      end
   end

endmodule : wst_top

// ---- wst_top_props.sv ----
// port-level checker for the weld step timing and monitor block
`timescale 1ns/1ps
`include "wst_params.svh"
module wst_top_props (
   input wire logic sys_clk_i, // clock
   input wire logic nrst_i, // reset
   input wire logic [7:0] addr_i, // address
   input wire logic [31:0] wr_data_i, // write data
   input wire logic wr_en_i, // write strobe
   input wire logic rd_en_i, // read strobe
   input wire logic [31:0] rd_data_o, // read data
   input wire logic fire_o, // firing pulse
   input wire wst_pkg::wst_pct_t fire_width_o, // firing width
   input wire logic electrode_close_o, // electrodes closed
   input wire wst_pkg::wst_state_t step_o, // step
   input wire logic irq_o // interrupt
);
   import wst_pkg::*;
   logic start_wr;
   assign start_wr = wr_en_i && addr_i == `WST_ADDR_CTRL && wr_data_i[`WST_CTRL_START];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_read_data_idle: assert property (!$past(rd_en_i) |-> rd_data_o == 32'h0)
      else $error("read data not zero outside answer cycle");
   a_fire_one_clk: assert property (fire_o |=> !fire_o)
      else $error("firing pulse longer than one clock");
   a_width_in_range: assert property (fire_width_o <= `WST_PCT_MAX)
      else $error("firing width above range");
   a_width_held: assert property (!fire_o |-> $stable(fire_width_o))
      else $error("firing width moved without a firing pulse");
   a_close_level: assert property (electrode_close_o == (step_o != WST_IDLE && step_o != WST_OFF))
      else $error("electrode close level wrong for step");
   a_fire_in_weld: assert property (fire_o |-> step_o inside {WST_FIRST_WELD_STEP, WST_SLOPE, WST_SECOND_WELD_STEP})
      else $error("firing outside a weld step");
   a_start_to_weld: assert property (start_wr && step_o == WST_IDLE |=> step_o == WST_FIRST_WELD_STEP)
      else $error("start did not enter first weld step");
   a_idle_needs_start: assert property (!start_wr && step_o == WST_IDLE |=> step_o == WST_IDLE)
      else $error("idle left without start");
   a_mask_off_irq: assert property (wr_en_i && addr_i == `WST_ADDR_MASK && wr_data_i == 32'h0 |=> !irq_o)
      else $error("interrupt high with mask cleared");
endmodule : wst_top_props

bind wst_top wst_top_props chk_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
   .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
   .fire_o(fire_o), .fire_width_o(fire_width_o), .electrode_close_o(electrode_close_o),
   .step_o(step_o), .irq_o(irq_o));
